// [hw/psfb_pkg.sv]
// constants, flag layout and register map of the special flag bank
//
// Overview of operation
// RULE1: program never targets flags from advanced instructions
// RULE2: input refresh loads the thirty refresh relays
// RULE3: software leaves reserved flag positions unchanged
// RULE4: carry/borrow read-only, cleared on stop, power-up
// RULE5: program fault read-only, cleared on stop, power-up
// RULE6: three slave link faults keep updating while stopped
// RULE7: summer-time flag read-only, updates while stopped
// RULE8: four write-only calendar/clock request flags
// RULE9: calendar/clock write and read faults, read-only
// RULE10: write-only receive cancel for ports two, three
// RULE11: hold-outputs flag read/write, kept over stop
// RULE12: card state and card busy read-only, kept
// RULE13: counter one control and status flag set
// RULE14: counter two reduced flag set
// RULE15: counter three same flag set as one
// RULE16: per-bit stop-clear and power-on clear classes
package psfb_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_FLAGS_LO = 4'h0;
  localparam logic [3:0] ADDR_FLAGS_HI = 4'h4;
  localparam logic [3:0] ADDR_REFRESH = 4'h8;

  localparam int FLAG_W = 64;
  localparam int REFRESH_W = 30;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [FLAG_W-1:0] FLAG_RST = 64'h0;
  localparam logic [REFRESH_W-1:0] REFRESH_RST = 30'h0;

  // ----------------------------------------------------------------
  // flag bit positions: octal flag number taken as the bit index
  // ----------------------------------------------------------------
  localparam int B_CARRY = 3;
  localparam int B_PROG_FAULT = 4;
  localparam int B_SLAVE1 = 5;
  localparam int B_SLAVE2 = 6;
  localparam int B_SLAVE3 = 7;
  localparam int B_SUMMER = 8;
  localparam int B_RTC_WR_FAULT = 11;
  localparam int B_RTC_RD_FAULT = 12;
  localparam int B_DATE_WR = 14;
  localparam int B_TIME_WR = 15;
  localparam int B_DATETIME_WR = 16;
  localparam int B_TIME_ADJ = 17;
  localparam int B_P2_CANCEL = 18;
  localparam int B_P3_CANCEL = 19;
  localparam int B_HOLD_OUT = 21;
  localparam int B_CARD_STATE = 22;
  localparam int B_CARD_BUSY = 23;
  localparam int B_C1_CMP_CLR = 24;
  localparam int B_C1_GATE = 25;
  localparam int B_C1_RST_IN = 26;
  localparam int B_C1_RST_ST = 27;
  localparam int B_C1_MATCH = 28;
  localparam int B_C1_OVER = 29;
  localparam int B_C1_UNDER = 30;
  localparam int B_C1_DIR = 31;
  localparam int B_C2_CMP_CLR = 32;
  localparam int B_C2_GATE = 33;
  localparam int B_C2_RST_IN = 34;
  localparam int B_C2_MATCH = 35;
  localparam int B_C2_OVER = 36;
  localparam int B_C3_CMP_CLR = 37;
  localparam int B_C3_GATE = 38;
  localparam int B_C3_RST_IN = 39;
  localparam int B_C3_RST_ST = 40;
  localparam int B_C3_MATCH = 41;
  localparam int B_C3_OVER = 42;
  localparam int B_C3_UNDER = 43;
  localparam int B_C3_DIR = 44;

  // ----------------------------------------------------------------
  // access and stop-behaviour classes
  // ----------------------------------------------------------------
  // status driven by cpu logic, read-only to software
  localparam logic [FLAG_W-1:0] HW_MASK = 64'h0000_1f18_f8c0_19f8;
  // write-only one-shot requests, read as zero
  localparam logic [FLAG_W-1:0] REQ_MASK = 64'h0000_0000_000f_c000;
  // read/write control flags
  localparam logic [FLAG_W-1:0] SW_MASK = 64'h0000_00e7_0720_0000;
  // forced to zero while the cpu is stopped
  localparam logic [FLAG_W-1:0] CLR_MASK = 64'h0000_0021_0100_0018;
  // frozen while the cpu is stopped
  localparam logic [FLAG_W-1:0] HOLD_MASK = 64'h0000_1fde_fee0_0000;
  localparam logic [FLAG_W-1:0] RD_MASK = HW_MASK | SW_MASK;
  localparam logic [FLAG_W-1:0] WR_MASK = SW_MASK;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK = 2'h2
  } psfb_bus_st_t;

endpackage : psfb_pkg

// [hw/psfb_bank_if.sv]
// link between the bus side and the flag storage
`timescale 1ns/1ps
interface psfb_bank_if;
  logic stop;
  logic [psfb_pkg::FLAG_W-1:0] upd;
  logic [psfb_pkg::FLAG_W-1:0] d;
  logic [psfb_pkg::FLAG_W-1:0] q;

  modport owner (output stop, output upd, output d, input q);
  modport bank (input stop, input upd, input d, output q);
endinterface : psfb_bank_if

// [hw/psfb_flag_bank.sv]
// flag storage with per-bit stop behaviour and power-on clear
`timescale 1ns/1ps
module psfb_flag_bank (
  input wire logic i_clk,
  input wire logic i_rst_b,
  psfb_bank_if.bank bank
);

  typedef struct packed {
    logic [psfb_pkg::FLAG_W-1:0] flags;
  } psfb_bank_st_t;

  psfb_bank_st_t st_r;
  psfb_bank_st_t st_nxt;
  logic [psfb_pkg::FLAG_W-1:0] run_val;

  // ----------------------------------------------------------------
  // next value per retention class
  // ----------------------------------------------------------------
  always_comb begin
    run_val = (bank.upd & bank.d) | (~bank.upd & st_r.flags);
    st_nxt = st_r;
    if (bank.stop) begin
      // operating bits keep updating, held bits freeze, cleared bits drop [RULE16]
      st_nxt.flags = (run_val & ~psfb_pkg::CLR_MASK & ~psfb_pkg::HOLD_MASK)
                   | (st_r.flags & psfb_pkg::HOLD_MASK);
    end else begin
      st_nxt.flags = run_val;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_r.flags <= psfb_pkg::FLAG_RST; // [RULE16]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bank.q = st_r.flags;

endmodule : psfb_flag_bank

// [hw/psfb_top.sv]
// special flag bank with avalon-mm register access
`timescale 1ns/1ps
module psfb_top (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_cpu_stop,
  input wire logic i_carry_indicator,
  input wire logic i_borrow_indicator,
  input wire logic i_program_fault_flag,
  input wire logic i_slave1_link_fault,
  input wire logic i_slave2_link_fault,
  input wire logic i_slave3_link_fault,
  input wire logic i_summer_time_flag,
  input wire logic i_rtc_write_fault,
  input wire logic i_rtc_read_fault,
  input wire logic i_card_state_flag,
  input wire logic i_card_write_busy,
  input wire logic i_cnt1_reset_state,
  input wire logic i_cnt1_match,
  input wire logic i_cnt1_over,
  input wire logic i_cnt1_under,
  input wire logic i_cnt1_direction,
  input wire logic i_cnt2_match,
  input wire logic i_cnt2_over,
  input wire logic i_cnt3_reset_state,
  input wire logic i_cnt3_match,
  input wire logic i_cnt3_over,
  input wire logic i_cnt3_under,
  input wire logic i_cnt3_direction,
  input wire logic i_input_refresh_instr,
  input wire logic [29:0] i_refresh_inputs,
  output logic o_date_write_request,
  output logic o_time_write_request,
  output logic o_datetime_write_request,
  output logic o_time_adjust_request,
  output logic o_port2_rx_cancel,
  output logic o_port3_rx_cancel,
  output logic o_hold_outputs_on_stop,
  output logic o_cnt1_cmp_out_clear,
  output logic o_cnt1_gate,
  output logic o_cnt1_reset_in,
  output logic o_cnt2_cmp_out_clear,
  output logic o_cnt2_gate,
  output logic o_cnt2_reset_in,
  output logic o_cnt3_cmp_out_clear,
  output logic o_cnt3_gate,
  output logic o_cnt3_reset_in
);

  typedef struct packed {
    psfb_pkg::psfb_bus_st_t bus_st;
    logic waitreq;
    logic [31:0] rdata;
    logic [psfb_pkg::REFRESH_W-1:0] refresh;
  } psfb_top_st_t;

  psfb_top_st_t st_r;
  psfb_top_st_t st_nxt;
  psfb_bank_if bank_if ();

  logic [psfb_pkg::FLAG_W-1:0] hw_vec;
  logic [psfb_pkg::FLAG_W-1:0] wr_mask;
  logic [psfb_pkg::FLAG_W-1:0] wr_data;
  logic wr_take;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] psfb_be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : psfb_be_mask

  function automatic logic [31:0] psfb_read_word(
    input logic [3:0] addr,
    input logic [psfb_pkg::FLAG_W-1:0] flags,
    input logic [psfb_pkg::REFRESH_W-1:0] refresh
  );
    logic [psfb_pkg::FLAG_W-1:0] vis;
    logic [31:0] w;
    vis = flags & psfb_pkg::RD_MASK;
    case (addr)
      psfb_pkg::ADDR_FLAGS_LO: w = vis[31:0];
      psfb_pkg::ADDR_FLAGS_HI: w = vis[63:32];
      psfb_pkg::ADDR_REFRESH: w = {2'h0, refresh};
      default: w = psfb_pkg::RDATA_RST;
    endcase
    return w;
  endfunction : psfb_read_word

  // ----------------------------------------------------------------
  // status image from cpu logic
  // ----------------------------------------------------------------
  always_comb begin
    hw_vec = psfb_pkg::FLAG_RST;
    hw_vec[psfb_pkg::B_CARRY] = i_carry_indicator | i_borrow_indicator; // [RULE4]
    hw_vec[psfb_pkg::B_PROG_FAULT] = i_program_fault_flag; // [RULE5]
    hw_vec[psfb_pkg::B_SLAVE1] = i_slave1_link_fault; // [RULE6]
    hw_vec[psfb_pkg::B_SLAVE2] = i_slave2_link_fault; // [RULE6]
    hw_vec[psfb_pkg::B_SLAVE3] = i_slave3_link_fault; // [RULE6]
    hw_vec[psfb_pkg::B_SUMMER] = i_summer_time_flag; // [RULE7]
    hw_vec[psfb_pkg::B_RTC_WR_FAULT] = i_rtc_write_fault; // [RULE9]
    hw_vec[psfb_pkg::B_RTC_RD_FAULT] = i_rtc_read_fault; // [RULE9]
    hw_vec[psfb_pkg::B_CARD_STATE] = i_card_state_flag; // [RULE12]
    hw_vec[psfb_pkg::B_CARD_BUSY] = i_card_write_busy; // [RULE12]
    hw_vec[psfb_pkg::B_C1_RST_ST] = i_cnt1_reset_state; // [RULE13]
    hw_vec[psfb_pkg::B_C1_MATCH] = i_cnt1_match; // [RULE13]
    hw_vec[psfb_pkg::B_C1_OVER] = i_cnt1_over; // [RULE13]
    hw_vec[psfb_pkg::B_C1_UNDER] = i_cnt1_under; // [RULE13]
    hw_vec[psfb_pkg::B_C1_DIR] = i_cnt1_direction; // [RULE13]
    hw_vec[psfb_pkg::B_C2_MATCH] = i_cnt2_match; // [RULE14]
    hw_vec[psfb_pkg::B_C2_OVER] = i_cnt2_over; // [RULE14]
    hw_vec[psfb_pkg::B_C3_RST_ST] = i_cnt3_reset_state; // [RULE15]
    hw_vec[psfb_pkg::B_C3_MATCH] = i_cnt3_match; // [RULE15]
    hw_vec[psfb_pkg::B_C3_OVER] = i_cnt3_over; // [RULE15]
    hw_vec[psfb_pkg::B_C3_UNDER] = i_cnt3_under; // [RULE15]
    hw_vec[psfb_pkg::B_C3_DIR] = i_cnt3_direction; // [RULE15]
  end

  // ----------------------------------------------------------------
  // bus write decode
  // ----------------------------------------------------------------
  // a write lands only at the edge where waitrequest is seen low
  assign wr_take = (st_r.bus_st == psfb_pkg::BUS_ACK) & i_avs_write;

  always_comb begin
    wr_mask = psfb_pkg::FLAG_RST;
    wr_data = psfb_pkg::FLAG_RST;
    if (wr_take) begin
      case (i_avs_address)
        psfb_pkg::ADDR_FLAGS_LO: begin
          wr_mask[31:0] = psfb_be_mask(i_avs_byteenable);
          wr_data[31:0] = i_avs_writedata;
        end
        psfb_pkg::ADDR_FLAGS_HI: begin
          wr_mask[63:32] = psfb_be_mask(i_avs_byteenable);
          wr_data[63:32] = i_avs_writedata;
        end
        default: begin
          wr_mask = psfb_pkg::FLAG_RST;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // flag bank feed
  // ----------------------------------------------------------------
  assign bank_if.stop = i_cpu_stop;
  // read-only and reserved bits never take bus data [RULE4] [RULE5] [RULE12]
  // requests are rewritten every cycle, so a set bit lives one cycle [RULE8] [RULE10]
  assign bank_if.upd = psfb_pkg::HW_MASK | psfb_pkg::REQ_MASK
                     | (wr_mask & psfb_pkg::WR_MASK); // [RULE11] [RULE13]
  assign bank_if.d = (hw_vec & psfb_pkg::HW_MASK)
                   | (wr_data & wr_mask & (psfb_pkg::REQ_MASK | psfb_pkg::WR_MASK));

  psfb_flag_bank u_bank (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .bank(bank_if)
  );

  // ----------------------------------------------------------------
  // bus handshake and refresh relays
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r.bus_st)
      psfb_pkg::BUS_IDLE: begin
        if (i_avs_read | i_avs_write) begin
          st_nxt.bus_st = psfb_pkg::BUS_ACK;
          st_nxt.waitreq = 1'b0;
          st_nxt.rdata = i_avs_read ?
            psfb_read_word(i_avs_address, bank_if.q, st_r.refresh) : psfb_pkg::RDATA_RST;
        end
      end
      psfb_pkg::BUS_ACK: begin
        st_nxt.bus_st = psfb_pkg::BUS_IDLE;
        st_nxt.waitreq = 1'b1;
      end
      default: begin
        st_nxt.bus_st = psfb_pkg::BUS_IDLE;
        st_nxt.waitreq = 1'b1;
      end
    endcase
    if (i_input_refresh_instr) begin
      st_nxt.refresh = i_refresh_inputs; // [RULE2]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_r.bus_st <= psfb_pkg::BUS_IDLE;
      st_r.waitreq <= 1'b1;
      st_r.rdata <= psfb_pkg::RDATA_RST;
      st_r.refresh <= psfb_pkg::REFRESH_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_avs_readdata = st_r.rdata;
  assign o_avs_waitrequest = st_r.waitreq;
  assign o_date_write_request = bank_if.q[psfb_pkg::B_DATE_WR];
  assign o_time_write_request = bank_if.q[psfb_pkg::B_TIME_WR];
  assign o_datetime_write_request = bank_if.q[psfb_pkg::B_DATETIME_WR];
  assign o_time_adjust_request = bank_if.q[psfb_pkg::B_TIME_ADJ];
  assign o_port2_rx_cancel = bank_if.q[psfb_pkg::B_P2_CANCEL];
  assign o_port3_rx_cancel = bank_if.q[psfb_pkg::B_P3_CANCEL];
  assign o_hold_outputs_on_stop = bank_if.q[psfb_pkg::B_HOLD_OUT];
  assign o_cnt1_cmp_out_clear = bank_if.q[psfb_pkg::B_C1_CMP_CLR];
  assign o_cnt1_gate = bank_if.q[psfb_pkg::B_C1_GATE];
  assign o_cnt1_reset_in = bank_if.q[psfb_pkg::B_C1_RST_IN];
  assign o_cnt2_cmp_out_clear = bank_if.q[psfb_pkg::B_C2_CMP_CLR];
  assign o_cnt2_gate = bank_if.q[psfb_pkg::B_C2_GATE];
  assign o_cnt2_reset_in = bank_if.q[psfb_pkg::B_C2_RST_IN];
  assign o_cnt3_cmp_out_clear = bank_if.q[psfb_pkg::B_C3_CMP_CLR];
  assign o_cnt3_gate = bank_if.q[psfb_pkg::B_C3_GATE];
  assign o_cnt3_reset_in = bank_if.q[psfb_pkg::B_C3_RST_IN];

endmodule : psfb_top

// [tb/psfb_props.sv]
// port-level assertions for the special flag bank
`timescale 1ns/1ps
module psfb_props (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  input wire logic i_cpu_stop,
  input wire logic o_date_write_request,
  input wire logic o_port2_rx_cancel,
  input wire logic o_hold_outputs_on_stop,
  input wire logic o_cnt1_cmp_out_clear,
  input wire logic o_cnt2_cmp_out_clear,
  input wire logic o_cnt3_cmp_out_clear
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  logic [2:0] clr_outs;
  assign clr_outs = {o_cnt3_cmp_out_clear, o_cnt2_cmp_out_clear, o_cnt1_cmp_out_clear};
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  // a write accepted at this edge to the low flag word
  sequence s_lo_wr;
    i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0;
  endsequence
  property p_ack; s_req |=> !o_avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("no bus answer");
  property p_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_idle;
    !i_avs_read && !i_avs_write && o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  // the request bit sits in byte lane one, so the lane must be enabled
  property p_date;
    s_lo_wr ##0 (i_avs_writedata[14] && i_avs_byteenable[1])
      |=> o_date_write_request ##1 !o_date_write_request;
  endproperty
  a_date: assert property (p_date) else $error("date request pulse wrong");
  property p_cancel;
    $rose(o_port2_rx_cancel)
      |-> $past(i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0);
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel without write");
  property p_stop_clr; i_cpu_stop |=> clr_outs == 3'h0; endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("compare clear kept on stop");
  property p_hold_frozen; i_cpu_stop |=> $stable(o_hold_outputs_on_stop); endproperty
  a_hold_frozen: assert property (p_hold_frozen) else $error("hold flag moved on stop");
  property p_hold_set;
    s_lo_wr ##0 (i_avs_writedata[21] && i_avs_byteenable[2] && !i_cpu_stop)
      |=> o_hold_outputs_on_stop;
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("hold flag not set");
  property p_hold_cause;
    !$stable(o_hold_outputs_on_stop)
      |-> $past(i_avs_write && !o_avs_waitrequest && !i_cpu_stop);
  endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("hold flag changed alone");
endmodule : psfb_props

bind psfb_top psfb_props psfb_props_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_avs_byteenable(i_avs_byteenable),
  .i_cpu_stop(i_cpu_stop), .o_date_write_request(o_date_write_request),
  .o_port2_rx_cancel(o_port2_rx_cancel), .o_hold_outputs_on_stop(o_hold_outputs_on_stop),
  .o_cnt1_cmp_out_clear(o_cnt1_cmp_out_clear), .o_cnt2_cmp_out_clear(o_cnt2_cmp_out_clear),
  .o_cnt3_cmp_out_clear(o_cnt3_cmp_out_clear));

// [tb/tb.sv]
// self-checking bench for the special flag bank
`timescale 1ns/1ps
module tb;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_cpu_stop = 1'b0, bw = 1'b0;
  logic i_avs_read = 1'b0, i_avs_write = 1'b0, i_input_refresh_instr = 1'b0;
  logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd;
  logic o_avs_waitrequest;
  logic [63:0] hw = 64'h0;
  logic [29:0] i_refresh_inputs = 30'h0;
  wire [63:0] outv;
  int failures, checked;
  int pc[6];

  psfb_top psfb_top_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_cpu_stop(i_cpu_stop),
    .i_carry_indicator(hw[3]), .i_borrow_indicator(bw), .i_program_fault_flag(hw[4]),
    .i_slave1_link_fault(hw[5]), .i_slave2_link_fault(hw[6]), .i_slave3_link_fault(hw[7]),
    .i_summer_time_flag(hw[8]), .i_rtc_write_fault(hw[11]), .i_rtc_read_fault(hw[12]),
    .i_card_state_flag(hw[22]), .i_card_write_busy(hw[23]), .i_cnt1_reset_state(hw[27]),
    .i_cnt1_match(hw[28]), .i_cnt1_over(hw[29]), .i_cnt1_under(hw[30]),
    .i_cnt1_direction(hw[31]), .i_cnt2_match(hw[35]), .i_cnt2_over(hw[36]),
    .i_cnt3_reset_state(hw[40]), .i_cnt3_match(hw[41]), .i_cnt3_over(hw[42]),
    .i_cnt3_under(hw[43]), .i_cnt3_direction(hw[44]),
    .i_input_refresh_instr(i_input_refresh_instr), .i_refresh_inputs(i_refresh_inputs),
    .o_date_write_request(outv[14]), .o_time_write_request(outv[15]),
    .o_datetime_write_request(outv[16]), .o_time_adjust_request(outv[17]),
    .o_port2_rx_cancel(outv[18]), .o_port3_rx_cancel(outv[19]),
    .o_hold_outputs_on_stop(outv[21]), .o_cnt1_cmp_out_clear(outv[24]),
    .o_cnt1_gate(outv[25]), .o_cnt1_reset_in(outv[26]), .o_cnt2_cmp_out_clear(outv[32]),
    .o_cnt2_gate(outv[33]), .o_cnt2_reset_in(outv[34]), .o_cnt3_cmp_out_clear(outv[37]),
    .o_cnt3_gate(outv[38]), .o_cnt3_reset_in(outv[39]));

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  // pulses last one cycle, so count them mid-cycle, away from the launching edge
  always @(negedge i_clk) begin
    for (int i = 0; i < 6; i++) begin
      pc[i] += int'(outv[14+i] === 1'b1);
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (e !== g) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be);
    int n;
    n = 0;
    i_avs_write <= w;
    i_avs_read <= ~w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    // look mid-cycle so the edge that takes the answer is the next one
    do begin
      @(negedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      failures++;
      tally_and_finish();
    end
    @(posedge i_clk);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_clk);
  endtask : bus

  task automatic rd64(output logic [63:0] v);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    v[31:0] = rd;
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    v[63:32] = rd;
  endtask : rd64

  task automatic wr64(input logic [63:0] d, input logic [7:0] be);
    bus(1'b1, 4'h0, d[31:0], be[3:0]);
    bus(1'b1, 4'h4, d[63:32], be[7:4]);
  endtask : wr64

  task automatic t_power;
    logic [63:0] v;
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    hw <= 64'h0;
    bw <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    chk("outputs", 64'h0, outv & (psfb_pkg::SW_MASK | psfb_pkg::REQ_MASK));
    rd64(v);
    chk("flags", 64'h0, v);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk("refresh", 64'h0, {32'h0, rd});
    $display("t_power done");
  endtask : t_power

  task automatic t_req;
    logic [63:0] v;
    for (int i = 0; i < 6; i++) begin
      i_cpu_stop <= i[0];
      wr64(64'h1 << (14 + i), 8'h0f);
    end
    i_cpu_stop <= 1'b0;
    rd64(v);
    chk("request readback", 64'h0, v & psfb_pkg::REQ_MASK);
    for (int i = 0; i < 6; i++) begin
      chk("request pulses", 64'h1, 64'(pc[i]));
    end
    $display("t_req done");
  endtask : t_req

  task automatic t_rw;
    logic [63:0] v, sw;
    hw <= 64'h0000_0a5a_a5a5_a5a5;
    bw <= 1'b1;
    sw = psfb_pkg::SW_MASK;
    // reserved positions are left at zero, read-only ones are tried
    wr64(psfb_pkg::RD_MASK, 8'hff);
    rd64(v);
    chk("flags", ((hw | 64'h8) & psfb_pkg::HW_MASK) | sw, v);
    chk("controls", sw, outv & sw);
    wr64(64'h0, 8'he7);
    chk("byte lanes", sw & ~(64'h1 << 21), outv & sw);
    $display("t_rw done");
  endtask : t_rw

  task automatic t_stop;
    logic [63:0] v, old, ex;
    old = hw;
    i_cpu_stop <= 1'b1;
    hw <= ~old;
    // ones try to move the frozen hold flag as well as the other controls
    wr64(psfb_pkg::SW_MASK, 8'hff);
    ex = (~old & 64'h19e0) | (old & psfb_pkg::HW_MASK & ~64'h19f8);
    ex = ex | (psfb_pkg::SW_MASK & ~64'h0000_0021_0120_0000);
    rd64(v);
    chk("stopped flags", ex, v);
    chk("stopped controls", ex & psfb_pkg::SW_MASK, outv & psfb_pkg::SW_MASK);
    i_cpu_stop <= 1'b0;
    // the read snapshot is the state after the previous edge, so let run be seen first
    @(posedge i_clk);
    rd64(v);
    ex = (~old & psfb_pkg::HW_MASK) | (ex & psfb_pkg::SW_MASK);
    chk("resumed flags", ex, v);
    $display("t_stop done");
  endtask : t_stop

  task automatic t_refresh;
    i_refresh_inputs <= 30'h2a5a_c3f1;
    i_input_refresh_instr <= 1'b1;
    @(posedge i_clk);
    i_input_refresh_instr <= 1'b0;
    i_refresh_inputs <= 30'h15a5_3c0e;
    bus(1'b1, 4'h8, 32'hffff_ffff, 4'hf);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk("refresh", 64'h2a5a_c3f1, {32'h0, rd});
    bus(1'b1, 4'hc, 32'hffff_ffff, 4'hf);
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    chk("unmapped", 64'h0, {32'h0, rd});
    $display("t_refresh done");
  endtask : t_refresh

  initial begin
    t_power();
    t_req();
    t_rw();
    t_stop();
    t_refresh();
    t_power();
    tally_and_finish();
  end
endmodule : tb
